//--- core/gpa_params.svh
/*
 * Offsets, reset values and timing figures of the GPIO port register slice.
 * Assumes it is included by bare name from the design files.
 */
`ifndef GPA_PARAMS_SVH
`define GPA_PARAMS_SVH

// Byte offsets inside the port window.
`define GPA_OFS_IRQ_MASK     12'h410
`define GPA_OFS_RAW_STATUS   12'h414
`define GPA_OFS_MASKED       12'h418
`define GPA_OFS_IRQ_CLEAR    12'h41c
`define GPA_OFS_FUNC_SEL     12'h420
`define GPA_OFS_DRIVE_LOW    12'h500
`define GPA_OFS_DRIVE_MID    12'h504
`define GPA_OFS_DRIVE_HIGH   12'h508

// Field position and width of every per-pin field.
`define GPA_FIELD_LSB        0
`define GPA_FIELD_MSB        7

// Reset values of the per-pin fields.
`define GPA_RST_ZERO         8'h00
`define GPA_RST_DRIVE_LOW    8'hff
`define GPA_RST_DRIVE_MID    8'h00
`define GPA_RST_DRIVE_HIGH   8'h00
`define GPA_RST_IRQ_MASK     8'h00

// Debug-pin sets of the three port variants.
`define GPA_DEBUG_NONE       8'h00
`define GPA_DEBUG_PIN7       8'h80
`define GPA_DEBUG_PINS3_0    8'h0f

// Clock edges from a drive write to the pad control output.
`define GPA_DRIVE_LATENCY    2

`endif

//--- core/gpa_pkg.sv
/*
 * Types shared by the GPIO port register slice.
 * Assumes nothing of its surroundings.
 */
package gpa_pkg;

    typedef logic [7:0] gpa_pins_type;

    typedef enum logic {
        GPA_BUS_IDLE,
        GPA_BUS_ANSWER
    } gpa_bus_state_type;

endpackage

//--- core/gpa_det_if.sv
/*
 * Carrier between the port top and one pin's interrupt detector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface gpa_det_if;
    logic sample;
    logic sense;
    logic event_high;
    logic both;
    logic clear;
    logic raw;

    modport detector (
        input  sample,
        input  sense,
        input  event_high,
        input  both,
        input  clear,
        output raw
    );

    modport port (
        output sample,
        output sense,
        output event_high,
        output both,
        output clear,
        input  raw
    );
endinterface

//--- core/gpa_pin_detect.sv
/*
 * Interrupt detector of one pin: edge latch or level compare.
 * Assumes the pin sample is synchronous to clk and rst_n is synchronised.
 */
`timescale 1ns/100ps
module gpa_pin_detect (
    // Clock and reset.
    input wire logic  clk,
    input wire logic  rst_n,
    // Link to the port top.
    gpa_det_if.detector det
);

    logic prev;
    logic latch;
    logic rise;
    logic fall;
    logic hit;

    assign rise = det.sample & ~prev;
    assign fall = ~det.sample & prev;
    assign hit  = det.both ? (rise | fall)
                           : (det.event_high ? rise : fall);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= det.sample;
        end
    end

    // A new edge in the clearing cycle wins over the clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 1'b0;
        end else if (det.sense) begin
            latch <= 1'b0;
        end else if (hit) begin
            latch <= 1'b1;
        end else if (det.clear) begin
            latch <= 1'b0;
        end
    end

    assign det.raw = det.sense ? (det.sample == det.event_high) : latch;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_clear_one_resets: assert property (
        (!det.sense && det.clear && !hit) |=> !latch)
        else $error("edge latch survived a clear");

    a_clear_zero_keeps: assert property (
        (!det.sense && latch && !det.clear) |=> latch)
        else $error("edge latch lost without a clear");

    a_edge_sets_latch: assert property (
        (!det.sense && hit) |=> latch)
        else $error("edge not latched");

endmodule

//--- core/gpa_port.sv
/*
 * GPIO port register slice: interrupt mask, status and clear, function
 * select with commit protection, exclusive drive strength selects.
 * Assumes an Avalon-MM master with byte addresses, pin inputs synchronous
 * to SYS_CLK, and lock and commit state supplied by neighbouring logic.
 */
// The Avalon-MM slave port was left to the implementer.
//
// Operation
// - Masked status bit reads 1 while its pin's masked interrupt is active.
// - Writing 1 to a clear bit resets that pin's edge latch; 0 does nothing. Here a new edge in the accepting cycle still sets the latch.
// - Clear register has eight bits at 7:0; bits 31:8 read zero.
// - Function select 1 gives the pin to hardware, 0 keeps software control.
// - Protected select bits change only when unlocked and committed.
// - Ordinary pins reset tristated; debug pins reset to alternate function.
// - Every reset returns all pins to their default configuration.
// - Select, pull-up and enable reset to 0, 0x80 or 0x0f by port.
// - Writing 1 to a low drive bit clears that pin's mid and high bits.
// - Writing 1 to mid or high drive clears the other two bits.
// - A drive write loads all eight bits of that strength; the other two strengths clear only where a 1 is written.
// - A drive change reaches the pad on the second edge after the write.
// - Masked status equals raw status AND mask, reset zero.
`timescale 1ns/100ps
`include "gpa_params.svh"

module gpa_port #(
    parameter logic [7:0] DEBUG_PINS = `GPA_DEBUG_NONE
) (
    // Clock and reset.
    input  wire logic         SYS_CLK,
    input  wire logic         RSTN,
    // Avalon-MM slave.
    input  wire logic [11:0]  AVS_ADDRESS,
    input  wire logic         AVS_READ,
    input  wire logic         AVS_WRITE,
    input  wire logic [31:0]  AVS_WRITEDATA,
    input  wire logic [3:0]   AVS_BYTEENABLE,
    output logic      [31:0]  AVS_READDATA,
    output logic              AVS_WAITREQUEST,
    // Pins and interrupt configuration.
    input  wire logic [7:0]   PIN_IN,
    input  wire logic [7:0]   IRQ_SENSE,
    input  wire logic [7:0]   IRQ_EVENT,
    input  wire logic [7:0]   IRQ_BOTH,
    // Commit protection.
    input  wire logic         LOCK_OPEN,
    input  wire logic [7:0]   COMMIT_EN,
    // Pad control.
    output logic      [7:0]   PIN_ALT_SEL,
    output logic      [7:0]   DRIVE_LOW,
    output logic      [7:0]   DRIVE_MID,
    output logic      [7:0]   DRIVE_HIGH,
    output logic      [7:0]   DIG_EN_DEFAULT,
    output logic      [7:0]   PULL_UP_DEFAULT,
    output logic      [7:0]   PULL_DOWN_DEFAULT,
    // Interrupt.
    output logic              IRQ
);

    logic [1:0]                 rst_pipe;
    logic                       rst_n;
    gpa_pkg::gpa_bus_state_type state;
    gpa_pkg::gpa_pins_type      irq_mask;
    gpa_pkg::gpa_pins_type      raw;
    gpa_pkg::gpa_pins_type      masked;
    gpa_pkg::gpa_pins_type      drv_low;
    gpa_pkg::gpa_pins_type      drv_mid;
    gpa_pkg::gpa_pins_type      drv_high;
    gpa_pkg::gpa_pins_type      commit_ok;
    gpa_pkg::gpa_pins_type      wd;
    gpa_pkg::gpa_pins_type      irq_clear;
    logic                       wr_ok;
    logic                       rd_start;
    logic [31:0]                next_readdata;

    // Reset release through two flip-flops.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Bus handshake: every request is answered one cycle after it appears.
    assign rd_start = (state == gpa_pkg::GPA_BUS_IDLE) & AVS_READ;
    assign wr_ok    = (state == gpa_pkg::GPA_BUS_ANSWER) & AVS_WRITE
                      & AVS_BYTEENABLE[0];
    assign wd       = AVS_WRITEDATA[`GPA_FIELD_MSB:`GPA_FIELD_LSB];

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= gpa_pkg::GPA_BUS_IDLE;
        end else begin
            unique case (state)
                gpa_pkg::GPA_BUS_IDLE: begin
                    if (AVS_READ || AVS_WRITE) begin
                        state <= gpa_pkg::GPA_BUS_ANSWER;
                    end
                end
                gpa_pkg::GPA_BUS_ANSWER: begin
                    state <= gpa_pkg::GPA_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((state == gpa_pkg::GPA_BUS_IDLE)
                                 && (AVS_READ || AVS_WRITE));
        end
    end

    // Read mux; unmapped and write-only locations read zero.
    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            `GPA_OFS_IRQ_MASK:   next_readdata[7:0] = irq_mask;
            `GPA_OFS_RAW_STATUS: next_readdata[7:0] = raw;
            `GPA_OFS_MASKED:     next_readdata[7:0] = masked;
            `GPA_OFS_FUNC_SEL:   next_readdata[7:0] = PIN_ALT_SEL;
            `GPA_OFS_DRIVE_LOW:  next_readdata[7:0] = drv_low;
            `GPA_OFS_DRIVE_MID:  next_readdata[7:0] = drv_mid;
            `GPA_OFS_DRIVE_HIGH: next_readdata[7:0] = drv_high;
            default:             next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (rd_start) begin
            AVS_READDATA <= next_readdata;
        end
    end

    // Interrupt mask.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `GPA_RST_IRQ_MASK;
        end else if (wr_ok && AVS_ADDRESS == `GPA_OFS_IRQ_MASK) begin
            irq_mask <= wd;
        end
    end

    // Clear pulses reach the detectors only on the accepting edge.
    assign irq_clear = (wr_ok && AVS_ADDRESS == `GPA_OFS_IRQ_CLEAR)
                       ? wd : `GPA_RST_ZERO;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        gpa_det_if det ();

        assign det.sample     = PIN_IN[i];
        assign det.sense      = IRQ_SENSE[i];
        assign det.event_high = IRQ_EVENT[i];
        assign det.both       = IRQ_BOTH[i];
        assign det.clear      = irq_clear[i];
        assign raw[i]         = det.raw;

        gpa_pin_detect u_detect (
            .clk   (SYS_CLK),
            .rst_n (rst_n),
            .det   (det)
        );
    end

    assign masked = raw & irq_mask;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |masked;
        end
    end

    // Debug pins accept a new select only when unlocked and committed.
    assign commit_ok = ~DEBUG_PINS | (COMMIT_EN & {8{LOCK_OPEN}});

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PIN_ALT_SEL <= DEBUG_PINS;
        end else if (wr_ok && AVS_ADDRESS == `GPA_OFS_FUNC_SEL) begin
            PIN_ALT_SEL <= (PIN_ALT_SEL & ~commit_ok)
                           | (wd & commit_ok);
        end
    end

    // Reset defaults of the neighbouring pull and enable registers.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            DIG_EN_DEFAULT    <= DEBUG_PINS;
            PULL_UP_DEFAULT   <= DEBUG_PINS;
            PULL_DOWN_DEFAULT <= `GPA_RST_ZERO;
        end else begin
            DIG_EN_DEFAULT    <= DIG_EN_DEFAULT;
            PULL_UP_DEFAULT   <= PULL_UP_DEFAULT;
            PULL_DOWN_DEFAULT <= PULL_DOWN_DEFAULT;
        end
    end

    // Drive selects: a 1 written to one strength clears the other two.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            drv_low  <= `GPA_RST_DRIVE_LOW;
            drv_mid  <= `GPA_RST_DRIVE_MID;
            drv_high <= `GPA_RST_DRIVE_HIGH;
        end else if (wr_ok) begin
            unique case (AVS_ADDRESS)
                `GPA_OFS_DRIVE_LOW: begin
                    drv_low  <= wd;
                    drv_mid  <= drv_mid & ~wd;
                    drv_high <= drv_high & ~wd;
                end
                `GPA_OFS_DRIVE_MID: begin
                    drv_mid  <= wd;
                    drv_low  <= drv_low & ~wd;
                    drv_high <= drv_high & ~wd;
                end
                `GPA_OFS_DRIVE_HIGH: begin
                    drv_high <= wd;
                    drv_low  <= drv_low & ~wd;
                    drv_mid  <= drv_mid & ~wd;
                end
                default: begin
                    drv_low  <= drv_low;
                end
            endcase
        end
    end

    // The pad stage adds the second edge before a new strength applies.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            DRIVE_LOW  <= `GPA_RST_DRIVE_LOW;
            DRIVE_MID  <= `GPA_RST_DRIVE_MID;
            DRIVE_HIGH <= `GPA_RST_DRIVE_HIGH;
        end else begin
            DRIVE_LOW  <= drv_low;
            DRIVE_MID  <= drv_mid;
            DRIVE_HIGH <= drv_high;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    a_masked_read: assert property (
        (rd_start && AVS_ADDRESS == `GPA_OFS_MASKED)
        |=> AVS_READDATA[7:0] == ($past(raw) & $past(irq_mask)))
        else $error("masked status read wrong");

    a_clear_reads_zero: assert property (
        (rd_start && AVS_ADDRESS == `GPA_OFS_IRQ_CLEAR)
        |=> AVS_READDATA == 32'h0000_0000)
        else $error("clear register read not zero");

    a_upper_bits_zero: assert property (
        !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
        else $error("reserved read bits not zero");

    a_select_protect: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_FUNC_SEL)
        |=> (PIN_ALT_SEL & ~$past(commit_ok))
            == ($past(PIN_ALT_SEL) & ~$past(commit_ok)))
        else $error("protected select bit changed");

    a_select_write: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_FUNC_SEL)
        |=> (PIN_ALT_SEL & $past(commit_ok))
            == ($past(wd) & $past(commit_ok)))
        else $error("select write not stored");

    a_reset_defaults: assert property (
        $rose(rst_n) |-> (PIN_ALT_SEL == DEBUG_PINS)
            && (drv_low == `GPA_RST_DRIVE_LOW)
            && (drv_mid == `GPA_RST_DRIVE_MID)
            && (PULL_UP_DEFAULT == DEBUG_PINS))
        else $error("reset defaults wrong");

    a_drive_exclusive: assert property (
        ((drv_low & drv_mid) | (drv_low & drv_high)
         | (drv_mid & drv_high)) == 8'h00)
        else $error("two drive strengths on one pin");

    a_drive_others: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_DRIVE_MID)
        |=> ((drv_low | drv_high) & ~$past(wd))
            == (($past(drv_low) | $past(drv_high)) & ~$past(wd)))
        else $error("drive write touched another pin");

    a_drive_latency: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_DRIVE_HIGH)
        |=> ##1 DRIVE_HIGH == $past(wd, 2))
        else $error("drive change not on second edge");

    a_irq_follows: assert property (
        (masked != 8'h00) |=> IRQ)
        else $error("interrupt not raised");

    a_answer_next: assert property (
        (state == gpa_pkg::GPA_BUS_IDLE && (AVS_READ || AVS_WRITE))
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not one cycle");

    a_irq_falls: assert property (
        (masked == 8'h00) |=> !IRQ)
        else $error("interrupt stuck high");

    a_low_latency: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_DRIVE_LOW)
        |=> ##1 DRIVE_LOW == $past(wd, 2))
        else $error("low drive not on second edge");

    a_mid_latency: assert property (
        (wr_ok && AVS_ADDRESS == `GPA_OFS_DRIVE_MID)
        |=> ##1 DRIVE_MID == $past(wd, 2))
        else $error("mid drive not on second edge");

    a_reset_drive: assert property (
        $rose(rst_n) |-> (DRIVE_LOW == `GPA_RST_DRIVE_LOW)
            && (DRIVE_MID == `GPA_RST_DRIVE_MID)
            && (drv_high == `GPA_RST_DRIVE_HIGH)
            && AVS_WAITREQUEST && !IRQ)
        else $error("drive reset values wrong");

    a_no_enable_ignored: assert property (
        (state == gpa_pkg::GPA_BUS_ANSWER && AVS_WRITE
         && !AVS_BYTEENABLE[0])
        |=> $stable(drv_low) && $stable(irq_mask) && $stable(PIN_ALT_SEL))
        else $error("write without byte enable took effect");

    a_pad_defaults: assert property (
        (PULL_DOWN_DEFAULT == `GPA_RST_ZERO)
        && (DIG_EN_DEFAULT == DEBUG_PINS) && (PULL_UP_DEFAULT == DEBUG_PINS))
        else $error("pad reset defaults changed");

    c_clear_write: cover property (
        wr_ok && AVS_ADDRESS == `GPA_OFS_IRQ_CLEAR && wd != 8'h00);
    c_protect_block: cover property (
        wr_ok && AVS_ADDRESS == `GPA_OFS_FUNC_SEL
        && (commit_ok != 8'hff));
    c_drive_high: cover property (
        wr_ok && AVS_ADDRESS == `GPA_OFS_DRIVE_HIGH && wd != 8'h00);
    c_irq_rise: cover property ($rose(IRQ));
    c_level_irq: cover property (|(IRQ_SENSE & masked));

endmodule

//--- tb/tb.sv
/*
 * Self-checking bench of the GPIO port register slice: reset values,
 * drive strength exclusivity and timing, protected function select,
 * interrupt status, mask and clear.
 * Assumes the port is built with debug pins 3:0 and a one-cycle bus answer.
 */
`timescale 1ns/100ps
`include "gpa_params.svh"

module tb;
    logic        sys_clk;
    logic        rstn;
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  ben;
    logic [31:0] rdata;
    logic        waitreq;
    logic [7:0]  pin_in;
    logic [7:0]  sense;
    logic [7:0]  event_hi;
    logic [7:0]  both;
    logic        lock_open;
    logic [7:0]  commit_en;
    logic [7:0]  alt_sel;
    logic [7:0]  drv_lo;
    logic [7:0]  drv_mi;
    logic [7:0]  drv_hi;
    logic [7:0]  den_def;
    logic [7:0]  pu_def;
    logic [7:0]  pd_def;
    logic        irq;
    int          bad_count;
    int          n_compared;
    logic [7:0]  exp_lo;
    logic [7:0]  exp_mi;
    logic [7:0]  exp_hi;
    logic [31:0] q;
    logic        t_lock [5]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0]  t_cmt [5]   = '{8'h0f, 8'h00, 8'h00, 8'h05, 8'h0f};
    logic [31:0] t_data [5]  = '{32'hffffff00, 32'hf0, 32'h0, 32'h0, 32'hff};
    logic [7:0]  t_exp [5]   = '{8'h0f, 8'hff, 8'h0f, 8'h0a, 8'hfa};

    gpa_port #(.DEBUG_PINS(`GPA_DEBUG_PINS3_0)) gpa_port_i (
        .SYS_CLK          (sys_clk),
        .RSTN             (rstn),
        .AVS_ADDRESS      (address),
        .AVS_READ         (read),
        .AVS_WRITE        (write),
        .AVS_WRITEDATA    (wdata),
        .AVS_BYTEENABLE   (ben),
        .AVS_READDATA     (rdata),
        .AVS_WAITREQUEST  (waitreq),
        .PIN_IN           (pin_in),
        .IRQ_SENSE        (sense),
        .IRQ_EVENT        (event_hi),
        .IRQ_BOTH         (both),
        .LOCK_OPEN        (lock_open),
        .COMMIT_EN        (commit_en),
        .PIN_ALT_SEL      (alt_sel),
        .DRIVE_LOW        (drv_lo),
        .DRIVE_MID        (drv_mi),
        .DRIVE_HIGH       (drv_hi),
        .DIG_EN_DEFAULT   (den_def),
        .PULL_UP_DEFAULT  (pu_def),
        .PULL_DOWN_DEFAULT(pd_def),
        .IRQ              (irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One request held until the edge at which waitrequest is seen low.
    task xfer(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
              input logic [3:0] be);
        int n;
        @(posedge sys_clk);
        address <= a;
        wdata   <= d;
        ben     <= be;
        read    <= !is_wr;
        write   <= is_wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (waitreq !== 1'b0) begin
            bad_count++;
            $display("FAIL bus answer expected 0 seen %b", waitreq);
            summarize();
        end
        q = rdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask

    task rchk(input string what, input logic [11:0] a,
              input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(what, exp, q);
    endtask

    task chk_drv(input string what);
        chk(what, {8'h00, exp_lo, exp_mi, exp_hi},
            {8'h00, drv_lo, drv_mi, drv_hi});
    endtask

    // Drive write with reserved bits set; pads must lag by one more edge.
    task dwr(input logic [11:0] a, input logic [7:0] v);
        wr(a, {24'hffffff, v});
        #1 chk_drv("drive pads before");
        exp_lo = (a == `GPA_OFS_DRIVE_LOW)  ? v : exp_lo & ~v;
        exp_mi = (a == `GPA_OFS_DRIVE_MID)  ? v : exp_mi & ~v;
        exp_hi = (a == `GPA_OFS_DRIVE_HIGH) ? v : exp_hi & ~v;
        @(posedge sys_clk);
        #1 chk_drv("drive pads after");
        rchk("drive low reg", `GPA_OFS_DRIVE_LOW, exp_lo);
        rchk("drive mid reg", `GPA_OFS_DRIVE_MID, exp_mi);
        rchk("drive high reg", `GPA_OFS_DRIVE_HIGH, exp_hi);
    endtask

    task chk_defaults;
        chk("alt select", 32'h0f, alt_sel);
        chk("dig enable default", 32'h0f, den_def);
        chk("pull up default", 32'h0f, pu_def);
        chk("pull down default", 32'h00, pd_def);
        exp_lo = 8'hff;
        exp_mi = 8'h00;
        exp_hi = 8'h00;
        chk_drv("drive reset");
        chk("irq reset", 32'h0, irq);
    endtask

    initial begin
        rstn = 1'b0;
        address = 12'h000;
        read = 1'b0;
        write = 1'b0;
        wdata = 32'h0;
        ben = 4'h0;
        pin_in = 8'h00;
        sense = 8'h00;
        event_hi = 8'hff;
        both = 8'h00;
        lock_open = 1'b0;
        commit_en = 8'h00;
        bad_count = 0;
        n_compared = 0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk_defaults();
        rchk("select reg", `GPA_OFS_FUNC_SEL, 32'h0f);
        rchk("low reg reset", `GPA_OFS_DRIVE_LOW, 32'hff);
        rchk("mid reg reset", `GPA_OFS_DRIVE_MID, 32'h0);
        rchk("masked reset", `GPA_OFS_MASKED, 32'h0);
        rchk("clear reg read", `GPA_OFS_IRQ_CLEAR, 32'h0);
        rchk("unmapped read", 12'h000, 32'h0);
        dwr(`GPA_OFS_DRIVE_MID, 8'h01);
        dwr(`GPA_OFS_DRIVE_HIGH, 8'h82);
        dwr(`GPA_OFS_DRIVE_LOW, 8'h03);
        dwr(`GPA_OFS_DRIVE_MID, 8'h10);
        xfer(1'b1, `GPA_OFS_DRIVE_LOW, 32'h0, 4'h0);
        rchk("no byte enable", `GPA_OFS_DRIVE_LOW, exp_lo);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            lock_open <= t_lock[i];
            commit_en <= t_cmt[i];
            wr(`GPA_OFS_FUNC_SEL, t_data[i]);
            @(posedge sys_clk);
            #1 chk("alt select pins", t_exp[i], alt_sel);
            rchk("select read", `GPA_OFS_FUNC_SEL, t_exp[i]);
        end
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk_defaults();
        @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pin_in <= 8'h24;
        rchk("raw edges", `GPA_OFS_RAW_STATUS, 32'h24);
        rchk("masked off", `GPA_OFS_MASKED, 32'h0);
        #1 chk("irq masked", 32'h0, irq);
        wr(`GPA_OFS_IRQ_MASK, 32'h04);
        rchk("masked on", `GPA_OFS_MASKED, 32'h04);
        #1 chk("irq on", 32'h1, irq);
        wr(`GPA_OFS_IRQ_CLEAR, 32'hffffff20);
        rchk("clear one pin", `GPA_OFS_RAW_STATUS, 32'h04);
        wr(`GPA_OFS_IRQ_CLEAR, 32'h04);
        rchk("cleared raw", `GPA_OFS_RAW_STATUS, 32'h0);
        @(posedge sys_clk);
        #1 chk("irq cleared", 32'h0, irq);
        @(posedge sys_clk);
        sense <= 8'h01;
        pin_in <= 8'h25;
        wr(`GPA_OFS_IRQ_MASK, 32'h01);
        wr(`GPA_OFS_IRQ_CLEAR, 32'h01);
        rchk("level raw", `GPA_OFS_RAW_STATUS, 32'h01);
        rchk("level masked", `GPA_OFS_MASKED, 32'h01);
        #1 chk("irq level", 32'h1, irq);
        @(posedge sys_clk);
        pin_in <= 8'h24;
        both <= 8'h08;
        rchk("level gone", `GPA_OFS_MASKED, 32'h0);
        @(posedge sys_clk);
        #1 chk("irq level gone", 32'h0, irq);
        @(posedge sys_clk);
        pin_in <= 8'h2c;
        wr(`GPA_OFS_IRQ_CLEAR, 32'h08);
        @(posedge sys_clk);
        pin_in <= 8'h24;
        rchk("both edges", `GPA_OFS_RAW_STATUS, 32'h08);
        @(posedge sys_clk);
        event_hi <= 8'hef;
        pin_in <= 8'h34;
        wr(`GPA_OFS_IRQ_CLEAR, 32'hff);
        // A falling edge on pin 4 lands on the edge that accepts its clear.
        fork
            wr(`GPA_OFS_IRQ_CLEAR, 32'h10);
            begin
                repeat (2) @(posedge sys_clk);
                pin_in <= 8'h24;
            end
        join
        rchk("edge beats clear", `GPA_OFS_RAW_STATUS, 32'h10);
        summarize();
    end
endmodule
